// ==== logic/ogt_pkg.sv ====
package ogt_pkg;
	// ==========================================
	// Widths
	localparam int FW = 16;
	localparam int TW = 10;
	// ==========================================
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_THR = 8'h04;
	localparam logic [7:0] ADDR_TIME = 8'h08;
	localparam logic [7:0] ADDR_MARGIN = 8'h0c;
	localparam logic [7:0] ADDR_NOTCH = 8'h10;
	localparam logic [7:0] ADDR_STAT = 8'h14;
	localparam logic [7:0] ADDR_MASK = 8'h18;
	localparam logic [7:0] ADDR_NOUT = 8'h1c;
	// ==========================================
	// Control bits
	localparam int CB_ENC = 0;
	localparam int CB_SPD = 1;
	localparam int CB_RST = 2;
	localparam int CB_LIM = 3;
	localparam int CB_PRE = 4;
	localparam int CB_TRQ = 5;
	localparam int CTRL_W = 6;
	localparam logic [5:0] CTRL_RST = 6'h00;
	// ==========================================
	// Status bits
	localparam int SB_DEV = 0;
	localparam int SB_PHL = 1;
	localparam int SB_OVS = 2;
	localparam int SB_LIM = 3;
	localparam int NSTAT = 4;
	// ==========================================
	// Notch field positions
	localparam int NF_SEL = 0;
	localparam int NF_DEP = 8;
	// ==========================================
	// Setting codes, frequencies in 0.01 Hz, time in 0.1 s
	localparam logic [15:0] THR_OFF = 16'h270f;
	localparam logic [15:0] THR_MAX = 16'h0bb8;
	localparam logic [9:0] TIME_RST = 10'h00a;
	localparam logic [9:0] TIME_MAX = 10'h3e8;
	localparam logic [15:0] MARGIN_RST = 16'h07d0;
	localparam logic [15:0] MARGIN_MAX = 16'h2ee0;
	localparam logic [5:0] NOTCH_MAX = 6'h3c;
	localparam logic [16:0] NOTCH_NUM = 17'h02710;
	// ==========================================
	// Notch gains in dB, deepest first
	localparam logic [7:0] GAIN_D0 = 8'hd8;
	localparam logic [7:0] GAIN_D1 = 8'hf2;
	localparam logic [7:0] GAIN_D2 = 8'hf8;
	localparam logic [7:0] GAIN_D3 = 8'hfc;
	// ==========================================
	// Timing
	localparam longint CLK_NS = 10;
	localparam longint TICK_NS = 100000000;
	localparam int TICK_CYC = int'(TICK_NS / CLK_NS);
endpackage

// ==== logic/ogt_timer_if.sv ====
`timescale 1ns/1ps
// ==========================================
// Persistence timer link
interface ogt_timer_if;
	logic run; // Excess deviation present
	logic [9:0] limit; // Allowed time in 0.1 s
	logic expired; // Excess outlasted the limit
	modport ctl(output run, output limit, input expired);
	modport tmr(input run, input limit, output expired);
endinterface

// ==== logic/ogt_persist_timer.sv ====
`timescale 1ns/1ps
// ==========================================
// Counts 0.1 s ticks while run holds
module ogt_persist_timer import ogt_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	ogt_timer_if.tmr tif
);
	logic [31:0] pre_r; // Prescaler
	logic [10:0] ticks_r; // Elapsed ticks
	logic tickNow;
	assign tickNow = (pre_r == 32'(TICK_CYCLES - 1));
	// Any drop of run restarts the count
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pre_r <= 32'h0;
			ticks_r <= 11'h0;
			tif.expired <= 1'b0;
		end else if (!tif.run) begin
			pre_r <= 32'h0;
			ticks_r <= 11'h0;
			tif.expired <= 1'b0;
		end else begin
			pre_r <= tickNow ? 32'h0 : pre_r + 32'h1;
			if (tickNow && ticks_r != 11'h7ff) begin
				ticks_r <= ticks_r + 11'h1;
			end
			tif.expired <= (ticks_r > {1'b0, tif.limit});
		end
	end
	// ==========================================
	// Checks
	timer_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		!tif.run |=> (ticks_r == 11'h0 && !tif.expired))
		else $error("timer not cleared");
endmodule

// ==== logic/overrun_guard.sv ====
`timescale 1ns/1ps
module overrun_guard import ogt_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [FW-1:0] cmdSpeed,
	input wire logic [FW-1:0] measSpeed,
	input wire logic [FW-1:0] setFreq,
	input wire logic [FW-1:0] maxFreq,
	input wire logic [FW-1:0] reqFreq,
	input wire logic [FW-1:0] speedLimit,
	output logic [FW:0] outFreq,
	output logic trip,
	output logic speedDevFault,
	output logic phaseLossFault,
	output logic overspeedFault,
	output logic torqueCtrlEn,
	output logic notchEn,
	output logic [FW-1:0] notchFreq,
	output logic [7:0] notchGain,
	output logic irq
);
	// ==========================================
	// Settings
	logic [CTRL_W-1:0] ctrl_r; // Mode bits
	logic [FW-1:0] devThr_r; // Deviation threshold
	logic [TW-1:0] devTime_r; // Deviation time
	logic [FW-1:0] margin_r; // Overrun margin
	logic [5:0] notchSel_r; // Notch selector
	logic [1:0] notchDepth_r; // Notch depth
	logic [NSTAT-1:0] stat_r; // Sticky events
	logic [NSTAT-1:0] mask_r; // Interrupt mask
	logic [FW:0] limitFreq_r; // Active clamp level

	// ==========================================
	// Bus decode
	logic setupPh; // Setup cycle
	logic wrEn; // Write takes effect
	logic hit; // Mapped address
	logic [31:0] rdMux; // Read selection
	assign setupPh = psel && !penable;
	assign wrEn = psel && penable && pready && pwrite;
	assign hit = (paddr[1:0] == 2'b00) && (paddr <= ADDR_NOUT);
	always_comb begin
		case (paddr)
			ADDR_CTRL: rdMux = {26'h0, ctrl_r};
			ADDR_THR: rdMux = {16'h0, devThr_r};
			ADDR_TIME: rdMux = {22'h0, devTime_r};
			ADDR_MARGIN: rdMux = {16'h0, margin_r};
			ADDR_NOTCH: rdMux = {22'h0, notchDepth_r, 2'b00, notchSel_r};
			ADDR_STAT: rdMux = {28'h0, stat_r};
			ADDR_MASK: rdMux = {28'h0, mask_r};
			ADDR_NOUT: rdMux = {8'h0, notchGain, notchFreq};
			default: rdMux = 32'h0;
		endcase
	end

	// ==========================================
	// Write saturation of out-of-range values
	logic [FW-1:0] thrIn;
	logic [TW-1:0] timeIn;
	logic [FW-1:0] marginIn;
	logic [5:0] selIn;
	assign thrIn = (pwdata[15:0] == THR_OFF || pwdata[15:0] <= THR_MAX) ?
		pwdata[15:0] : THR_MAX;
	assign timeIn = (pwdata[9:0] > TIME_MAX) ? TIME_MAX : pwdata[9:0];
	assign marginIn = (pwdata[15:0] > MARGIN_MAX) ? MARGIN_MAX : pwdata[15:0];
	assign selIn = (pwdata[NF_SEL +: 6] > NOTCH_MAX) ? NOTCH_MAX : pwdata[NF_SEL +: 6];

	// APB answer: no wait states, data caught in setup
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= setupPh;
			prdata <= setupPh ? (hit && !pwrite ? rdMux : 32'h0) : prdata;
			pslverr <= setupPh && !hit;
		end
	end

	// Setting registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= CTRL_RST;
			devThr_r <= THR_OFF;
			devTime_r <= TIME_RST;
			margin_r <= MARGIN_RST;
			notchSel_r <= 6'h00;
			notchDepth_r <= 2'b00;
			mask_r <= {NSTAT{1'b0}};
		end else if (wrEn && !pslverr) begin
			case (paddr)
				ADDR_CTRL: ctrl_r <= pwdata[CTRL_W-1:0];
				ADDR_THR: devThr_r <= thrIn;
				ADDR_TIME: devTime_r <= timeIn;
				ADDR_MARGIN: margin_r <= marginIn;
				ADDR_NOTCH: begin
					notchSel_r <= selIn;
					notchDepth_r <= pwdata[NF_DEP +: 2];
				end
				ADDR_MASK: mask_r <= pwdata[NSTAT-1:0];
				default: ;
			endcase
		end
	end

	// ==========================================
	// Speed deviation check
	logic thrOn; // Detection enabled
	logic devWindow; // Mode allows the check
	logic [FW-1:0] absErr; // Absolute speed error
	logic excess; // Error above threshold
	assign thrOn = (devThr_r != THR_OFF);
	assign devWindow = ctrl_r[CB_ENC] && ctrl_r[CB_SPD];
	assign absErr = (cmdSpeed >= measSpeed) ? cmdSpeed - measSpeed :
		measSpeed - cmdSpeed;
	assign excess = thrOn && devWindow && (absErr > devThr_r);

	ogt_timer_if tif();
	assign tif.run = excess;
	assign tif.limit = devTime_r;
	ogt_persist_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
		.core_clk(core_clk),
		.rst(rst),
		.tif(tif)
	);

	// ==========================================
	// Overspeed, speed limit and phase loss
	logic [FW:0] ovsLevel; // Overspeed level
	logic ovsEvt;
	logic limEngaged; // Speed limit acting
	logic [FW-1:0] effLimit; // Speed limit in use
	logic phlEvt;
	assign ovsLevel = {1'b0, maxFreq} + {1'b0, devThr_r};
	assign ovsEvt = ctrl_r[CB_ENC] && thrOn && ({1'b0, measSpeed} > ovsLevel);
	assign effLimit = ctrl_r[CB_LIM] ? speedLimit : 16'h0000;
	assign limEngaged = ctrl_r[CB_TRQ] && (measSpeed >= effLimit);
	assign phlEvt = limEngaged && ctrl_r[CB_PRE];

	// ==========================================
	// Events and interrupt
	logic [NSTAT-1:0] evt;
	logic [NSTAT-1:0] w1c;
	assign evt = {limEngaged, ovsEvt, phlEvt, tif.expired};
	assign w1c = (wrEn && !pslverr && paddr == ADDR_STAT) ? pwdata[NSTAT-1:0] : '0;

	// Sticky status: a new event beats a clear
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stat_r <= {NSTAT{1'b0}};
			irq <= 1'b0;
		end else begin
			stat_r <= (stat_r & ~w1c) | evt;
			irq <= |(((stat_r & ~w1c) | evt) & mask_r);
		end
	end

	// ==========================================
	// Frequency clamp
	logic [FW-1:0] clampBase;
	logic [FW:0] limitNxt;
	logic tripNxt;
	assign clampBase = ctrl_r[CB_RST] ? maxFreq : setFreq;
	assign limitNxt = {1'b0, clampBase} + {1'b0, margin_r};
	assign tripNxt = stat_r[SB_DEV] || stat_r[SB_PHL];

	// Output stage, shut off while tripped
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			limitFreq_r <= '0;
			outFreq <= '0;
			trip <= 1'b0;
			speedDevFault <= 1'b0;
			phaseLossFault <= 1'b0;
			overspeedFault <= 1'b0;
			torqueCtrlEn <= 1'b0;
		end else begin
			limitFreq_r <= limitNxt;
			trip <= tripNxt;
			if (tripNxt) begin
				outFreq <= '0;
			end else if ({1'b0, reqFreq} > limitNxt) begin
				outFreq <= limitNxt;
			end else begin
				outFreq <= {1'b0, reqFreq};
			end
			speedDevFault <= stat_r[SB_DEV];
			phaseLossFault <= stat_r[SB_PHL];
			overspeedFault <= stat_r[SB_OVS];
			torqueCtrlEn <= ctrl_r[CB_TRQ] && !limEngaged;
		end
	end

	// ==========================================
	// Notch setup
	logic [16:0] notchQ; // Rounded 10000/n in 0.1 Hz
	logic [7:0] gainSel;
	assign notchQ = (notchSel_r == 6'h00) ? 17'h0 :
		(NOTCH_NUM + 17'({notchSel_r[5:1]})) / 17'(notchSel_r);
	always_comb begin
		case (notchDepth_r)
			2'b00: gainSel = GAIN_D0;
			2'b01: gainSel = GAIN_D1;
			2'b10: gainSel = GAIN_D2;
			default: gainSel = GAIN_D3;
		endcase
	end

	// Notch outputs
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			notchEn <= 1'b0;
			notchFreq <= '0;
			notchGain <= GAIN_D0;
		end else begin
			notchEn <= (notchSel_r != 6'h00);
			notchFreq <= notchQ[FW-1:0];
			notchGain <= gainSel;
		end
	end

	// ==========================================
	// Checks
	thr_off_a: assert property (@(posedge core_clk) disable iff (rst)
		(devThr_r == THR_OFF) |-> !tif.run)
		else $error("detection ran while disabled");
	dev_window_a: assert property (@(posedge core_clk) disable iff (rst)
		tif.run |-> (ctrl_r[CB_ENC] && ctrl_r[CB_SPD] && absErr > devThr_r))
		else $error("deviation check outside window");
	dev_trip_a: assert property (@(posedge core_clk) disable iff (rst)
		tif.expired |=> stat_r[SB_DEV] ##1 (trip && outFreq == '0))
		else $error("expired excess did not trip");
	clamp_lvl_a: assert property (@(posedge core_clk) disable iff (rst)
		!tripNxt |=> (outFreq <= $past(limitNxt)))
		else $error("output above clamp");
	restart_clamp_a: assert property (@(posedge core_clk) disable iff (rst)
		ctrl_r[CB_RST] |=> (limitFreq_r == {1'b0, $past(maxFreq)} + {1'b0, $past(margin_r)}))
		else $error("restart clamp wrong");
	notch_off_a: assert property (@(posedge core_clk) disable iff (rst)
		(notchSel_r == 6'h00) |=> !notchEn)
		else $error("notch on with zero select");
	notch_gain_a: assert property (@(posedge core_clk) disable iff (rst)
		(notchDepth_r == 2'b00) |=> (notchGain == GAIN_D0))
		else $error("deep notch gain wrong");
	torque_susp_a: assert property (@(posedge core_clk) disable iff (rst)
		limEngaged |=> !torqueCtrlEn)
		else $error("torque kept under speed limit");
	no_limit_a: assert property (@(posedge core_clk) disable iff (rst)
		(ctrl_r[CB_TRQ] && !ctrl_r[CB_LIM]) |=> !torqueCtrlEn)
		else $error("torque with no limit set");
	phase_loss_a: assert property (@(posedge core_clk) disable iff (rst)
		phlEvt |=> stat_r[SB_PHL] ##1 phaseLossFault)
		else $error("phase loss not raised");
	ovs_level_a: assert property (@(posedge core_clk) disable iff (rst)
		(ctrl_r[CB_ENC] && thrOn && {1'b0, measSpeed} > ovsLevel) |=> stat_r[SB_OVS])
		else $error("overspeed missed");
	// Range, event and handshake checks
	thr_range_a: assert property (@(posedge core_clk) disable iff (rst)
		(devThr_r == THR_OFF) || (devThr_r <= THR_MAX))
		else $error("threshold out of range");
	time_range_a: assert property (@(posedge core_clk) disable iff (rst)
		devTime_r <= TIME_MAX)
		else $error("deviation time out of range");
	margin_range_a: assert property (@(posedge core_clk) disable iff (rst)
		margin_r <= MARGIN_MAX)
		else $error("margin out of range");
	expire_run_a: assert property (@(posedge core_clk) disable iff (rst)
		tif.expired |-> $past(tif.run))
		else $error("expiry without excess");
	event_sticky_a: assert property (@(posedge core_clk) disable iff (rst)
		(evt != '0) |=> ((stat_r & $past(evt)) == $past(evt)))
		else $error("event lost to a clear");
	pready_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
		pready |=> !pready)
		else $error("pready held high");
endmodule

// ==== tb/ogt_motor_model.sv ====
`timescale 1ns/1ps
// ==========================================
// Motor with shaft encoder, speed tracks the drive plus load slip
module ogt_motor_model import ogt_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [FW:0] outFreq,
	input wire logic [FW-1:0] slip,
	output logic [FW-1:0] measSpeed
);
	// Encoder speed lags the output by one cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			measSpeed <= '0;
		end else begin
			measSpeed <= outFreq[FW-1:0] + slip;
		end
	end
endmodule

// ==== tb/overrun_guard_tb_top.sv ====
`timescale 1ns/1ps
// ==========================================
// Register-level bench for the overrun guard
module overrun_guard_tb_top import ogt_pkg::*;;
	logic core_clk, rst, psel, penable, pwrite, pready, pslverr, lastErr; // Bus
	logic [7:0] paddr; // Byte address
	logic [31:0] pwdata, prdata, q; // Data
	logic [FW-1:0] cmdSpeed, measSpeed, setFreq, maxFreq, reqFreq, speedLimit, slip; // Speeds
	logic [FW:0] outFreq; // Clamped output
	logic trip, speedDevFault, phaseLossFault, overspeedFault, torqueCtrlEn, notchEn, irq;
	logic [FW-1:0] notchFreq; // Notch centre
	logic [7:0] notchGain; // Notch gain
	logic [7:0] gains [4] = '{8'hd8, 8'hf2, 8'hf8, 8'hfc}; // Deepest first
	int err_count = 0, compares = 0;
	// Design with a short tick
	overrun_guard #(.TICK_CYCLES(4)) i_dut (.core_clk(core_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmdSpeed(cmdSpeed), .measSpeed(measSpeed),
		.setFreq(setFreq), .maxFreq(maxFreq), .reqFreq(reqFreq), .speedLimit(speedLimit),
		.outFreq(outFreq), .trip(trip), .speedDevFault(speedDevFault),
		.phaseLossFault(phaseLossFault), .overspeedFault(overspeedFault),
		.torqueCtrlEn(torqueCtrlEn), .notchEn(notchEn), .notchFreq(notchFreq),
		.notchGain(notchGain), .irq(irq));
	// Far-side motor
	ogt_motor_model i_motor (.core_clk(core_clk), .rst(rst), .outFreq(outFreq), .slip(slip),
		.measSpeed(measSpeed));
	// 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One APB transfer, entered just after a rising edge
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) chk("pready", 32'h0, 32'h1);
		q = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask
	task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0);
		chk(nm, q, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Verdict
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		#400us;
		err_count++;
		tally_and_finish();
	end
	// Test sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{cmdSpeed, slip, speedLimit} = '0;
		setFreq = 16'h0bb8;
		reqFreq = 16'h0bb8;
		maxFreq = 16'h4e20;
		rst = 1'b1;
		cyc(2);
		rst <= 1'b0;
		cyc(1);
		chk("gainRst", 32'(notchGain), 32'h000000d8);
		rdChk("ctrl", ADDR_CTRL, 32'h0);
		rdChk("thr", ADDR_THR, 32'h0000270f);
		rdChk("time", ADDR_TIME, 32'h0000000a);
		rdChk("margin", ADDR_MARGIN, 32'h000007d0);
		rdChk("nout", ADDR_NOUT, 32'h00d80000);
		rdChk("unmap", 8'h20, 32'h0);
		chk("slverr", 32'(lastErr), 32'h1);
		$display("test reset done");
		cmdSpeed <= 16'h0bb8;
		slip <= 16'h00c8;
		wr(ADDR_CTRL, 32'h3);
		cyc(30);
		chk("offTrip", 32'(trip), 32'h0);
		wr(ADDR_THR, 32'h64);
		wr(ADDR_CTRL, 32'h1);
		cyc(30);
		chk("noSpdTrip", 32'(trip), 32'h0);
		wr(ADDR_TIME, 32'h1);
		wr(ADDR_CTRL, 32'h3);
		slip <= 16'h0064;
		cyc(30);
		chk("edgeTrip", 32'(trip), 32'h0);
		repeat (4) begin
			slip <= 16'h00c8;
			cyc(6);
			slip <= 16'h0000;
			cyc(2);
		end
		chk("burstTrip", 32'(trip), 32'h0);
		slip <= 16'h00c8;
		cyc(20);
		chk("devFault", 32'(speedDevFault), 32'h1);
		chk("trip", 32'(trip), 32'h1);
		chk("outOff", 32'(outFreq), 32'h0);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_STAT, 32'h1);
		slip <= 16'h0000;
		cyc(3);
		chk("tripClr", 32'(trip), 32'h0);
		chk("outBack", 32'(outFreq), 32'h00000bb8);
		maxFreq <= 16'h07d0;
		wr(ADDR_CTRL, 32'h1);
		cyc(4);
		chk("ovs", 32'(overspeedFault), 32'h1);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_STAT, 32'h4);
		$display("test deviation done");
		reqFreq <= 16'h4e20;
		cyc(3);
		chk("clampSet", 32'(outFreq), 32'h00000bb8 + 32'h7d0);
		wr(ADDR_MARGIN, 32'hffff);
		rdChk("marginMax", ADDR_MARGIN, 32'h00002ee0);
		cyc(2);
		chk("clampMax", 32'(outFreq), 32'h00000bb8 + 32'h2ee0);
		wr(ADDR_CTRL, 32'h4);
		cyc(3);
		chk("clampRst", 32'(outFreq), 32'h000007d0 + 32'h2ee0);
		$display("test clamp done");
		foreach (gains[i]) begin
			wr(ADDR_NOTCH, {22'h0, 2'(3 - i), 2'h0, 6'(i * 19 + 1)});
			cyc(2);
			chk("notchEn", 32'(notchEn), 32'h1);
			rdChk("nout", ADDR_NOUT, {gains[3 - i], 16'((20000 / (i * 19 + 1) + 1) / 2)});
		end
		wr(ADDR_NOTCH, 32'h0);
		cyc(2);
		chk("notchOff", 32'(notchEn), 32'h0);
		$display("test notch done");
		wr(ADDR_CTRL, 32'h20);
		cyc(3);
		chk("trqNoLim", 32'(torqueCtrlEn), 32'h0);
		rdChk("limSet", ADDR_STAT, 32'h00000008);
		speedLimit <= 16'hea60;
		wr(ADDR_CTRL, 32'h28);
		wr(ADDR_STAT, 32'h8);
		cyc(2);
		chk("trqOn", 32'(torqueCtrlEn), 32'h1);
		wr(ADDR_MASK, 32'h8);
		cyc(2);
		chk("irqIdle", 32'(irq), 32'h0);
		speedLimit <= 16'h0064;
		wr(ADDR_CTRL, 32'h38);
		cyc(2);
		chk("trqOff", 32'(torqueCtrlEn), 32'h0);
		chk("phLoss", 32'(phaseLossFault), 32'h1);
		chk("phlTrip", 32'(trip), 32'h1);
		chk("irqOn", 32'(irq), 32'h1);
		wr(ADDR_MASK, 32'h0);
		cyc(2);
		chk("irqMask", 32'(irq), 32'h0);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_STAT, 32'hf);
		cyc(2);
		rdChk("statClr", ADDR_STAT, 32'h0);
		chk("tripOff", 32'(trip), 32'h0);
		$display("test torque done");
		tally_and_finish();
	end
endmodule
